// ### inc/l1cc_consts.svh
// constants for the level-one cache coherency controller
`ifndef L1CC_CONSTS_SVH
`define L1CC_CONSTS_SVH
`define L1CC_ADDR_W 32
`define L1CC_LINE_LSB 5
`define L1CC_LINE_BYTES 32
`define L1CC_SINGLE_MAX_BYTES 8
`define L1CC_SINGLE_MIN_BYTES 1
`define L1CC_BEATS_PER_LINE 4
`define L1CC_IDX_BITS 3
`define L1CC_SETS 8
`endif

// ### inc/l1cc_pkg.sv
// types for the level-one cache coherency controller
package l1cc_pkg;
    // mesi state of a data line
    typedef enum logic [1:0] {
        L1CC_INV = 2'h0,
        L1CC_SHR = 2'h1,
        L1CC_EXC = 2'h2,
        L1CC_MOD = 2'h3
    } l1cc_mesi_t;
    // controller states, one-hot
    typedef enum logic [5:0] {
        L1CC_IDLE  = 6'h01,
        L1CC_WBACK = 6'h02,
        L1CC_FILL  = 6'h04,
        L1CC_WRITE = 6'h08,
        L1CC_PURGE = 6'h10,
        L1CC_PWB   = 6'h20
    } l1cc_state_t;
    // request from the core pipeline
    typedef struct packed {
        logic valid;
        logic isInstr;
        logic isWrite;
        logic [31:0] addr;
        logic [3:0] bytes;
    } l1cc_req_t;
    // bus cycle issued to memory
    typedef struct packed {
        logic valid;
        logic write;
        logic burst;
        logic [31:0] addr;
        logic [5:0] bytes;
    } l1cc_bus_t;
endpackage

// ### core/l1cc_coherency.sv
// coherency controller for split level-one instruction and data caches
//
// How it works
// - inquire compares both cache tag sets
// - clean or instruction hit raises match
// - modified hit raises match and dirty
// - dirty match always triggers burst writeback
// - kill flag invalidates hit, writeback first
// - no kill: data to shared, instr kept
// - misses snoop other cache, hits don't
// - instr miss: writeback, invalidate data line
// - data miss invalidates instruction line
// - purge input: writeback dirty, invalidate all
// - writeback-purge: writeback then invalidate all
// - discard-purge invalidates all, no memory
// - writethrough is single bus cycle
// - writeback is burst bus cycle
// - shared is writethrough, exclusive/modified writeback
// - fill 32-byte burst, singles 1-8
`timescale 1ns/1ps
`include "l1cc_consts.svh"
module l1cc_coherency
    import l1cc_pkg::*;
#(
    parameter int SETS = `L1CC_SETS,
    parameter int IDXW = `L1CC_IDX_BITS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic addrBusFloatReq,
    input wire logic abortRetryReq,
    input wire logic busYieldReq,
    input wire logic extAddrStrobe,
    input wire logic killLine,
    input wire logic [31:5] inquireAddrBits,
    input wire logic cachePurge,
    input wire logic writebackPurgeOp,
    input wire logic discardPurgeOp,
    input wire l1cc_req_t coreReq,
    input wire logic busDone,
    output logic snoopMatch,
    output logic snoopDirtyMatch,
    output l1cc_bus_t busCycle,
    output logic coreAck,
    output logic purgeBusy
);
    localparam int TAGW = 27 - IDXW;
    // tag stores: instruction valid bits, data mesi state
    logic [TAGW-1:0] iTag_reg [SETS];
    logic [SETS-1:0] iValid_reg;
    logic [TAGW-1:0] dTag_reg [SETS];
    l1cc_mesi_t dState_reg [SETS];
    l1cc_state_t state_reg;
    l1cc_req_t pend_reg;          // request held over a writeback
    logic [31:5] wbAddr_reg;      // line being written back
    logic [IDXW:0] scan_reg;      // purge walk index
    logic wbKeep_reg;             // purge does writebacks
    logic [IDXW-1:0] wbIdx_reg;
    logic wbInv_reg;              // invalidate after writeback
    // inquire decode
    wire busOwned = addrBusFloatReq | abortRetryReq | busYieldReq;
    wire inqGo = extAddrStrobe & busOwned;
    wire inqTake = inqGo & (state_reg == L1CC_IDLE); // strobes outside idle are dropped
    wire [IDXW-1:0] qIdx = inquireAddrBits[5 +: IDXW];
    wire [TAGW-1:0] qTag = inquireAddrBits[31 -: TAGW];
    wire qIHit = iValid_reg[qIdx] & (iTag_reg[qIdx] == qTag);
    wire qDHit = (dState_reg[qIdx] != L1CC_INV) & (dTag_reg[qIdx] == qTag);
    wire qDMod = qDHit & (dState_reg[qIdx] == L1CC_MOD);
    // core request decode
    wire [IDXW-1:0] rIdx = coreReq.addr[5 +: IDXW];
    wire [TAGW-1:0] rTag = coreReq.addr[31 -: TAGW];
    wire rIHit = iValid_reg[rIdx] & (iTag_reg[rIdx] == rTag);
    wire rDHit = (dState_reg[rIdx] != L1CC_INV) & (dTag_reg[rIdx] == rTag);
    wire rHit = coreReq.isInstr ? rIHit : rDHit;
    // cross snoop only on a miss
    wire xDHit = coreReq.isInstr & ~rIHit & rDHit;
    wire xIHit = ~coreReq.isInstr & ~rDHit & rIHit;
    wire xDMod = xDHit & (dState_reg[rIdx] == L1CC_MOD);
    // writethrough state of the hit data line
    wire rWThru = rDHit & (dState_reg[rIdx] == L1CC_SHR);
    wire purgeReq = cachePurge | writebackPurgeOp | discardPurgeOp;
    wire purgeKeep = cachePurge | writebackPurgeOp; // a writeback purge outranks discard
    wire [IDXW-1:0] sIdx = scan_reg[IDXW-1:0];
    wire sDirty = wbKeep_reg & (dState_reg[sIdx] == L1CC_MOD);
    wire [5:0] reqBytes = {2'h0, coreReq.bytes};
    // match outputs, one cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            snoopMatch <= 1'b0;
            snoopDirtyMatch <= 1'b0;
        end else begin
            snoopMatch <= inqTake & (qIHit | qDHit);
            snoopDirtyMatch <= inqTake & qDMod;
        end
    end
    // tag state updates
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            iValid_reg <= '0;
            for (int i = 0; i < SETS; i++) begin
                dState_reg[i] <= L1CC_INV;
                iTag_reg[i] <= '0;
                dTag_reg[i] <= '0;
            end
        end else if (state_reg == L1CC_PURGE) begin
            // whole-cache invalidate after any writebacks
            iValid_reg <= '0;
            for (int i = 0; i < SETS; i++) begin
                dState_reg[i] <= L1CC_INV;
            end
        end else if (inqGo && state_reg == L1CC_IDLE) begin
            if (killLine) begin
                // kill: invalidate non-dirty now, dirty after writeback
                if (qIHit) iValid_reg[qIdx] <= 1'b0;
                if (qDHit && !qDMod) dState_reg[qIdx] <= L1CC_INV;
            end else if (qDHit && !qDMod) begin
                dState_reg[qIdx] <= L1CC_SHR;
            end
        end else if (state_reg == L1CC_WBACK && busDone) begin
            // written back: invalidate or demote
            dState_reg[wbIdx_reg] <= wbInv_reg ? L1CC_INV : L1CC_SHR;
        end else if (state_reg == L1CC_PWB && busDone) begin
            dState_reg[sIdx] <= L1CC_INV;
        end else if (state_reg == L1CC_IDLE && coreReq.valid && !purgeReq) begin
            if (xIHit) iValid_reg[rIdx] <= 1'b0;
            if (xDHit && !xDMod) dState_reg[rIdx] <= L1CC_INV;
            if (coreReq.isWrite && rDHit && !rWThru) dState_reg[rIdx] <= L1CC_MOD;
        end else if (state_reg == L1CC_FILL && busDone) begin
            // fill completes: allocate the line
            if (pend_reg.isInstr) begin
                iValid_reg[pend_reg.addr[5 +: IDXW]] <= 1'b1;
                iTag_reg[pend_reg.addr[5 +: IDXW]] <= pend_reg.addr[31 -: TAGW];
            end else begin
                dState_reg[pend_reg.addr[5 +: IDXW]] <= L1CC_EXC;
                dTag_reg[pend_reg.addr[5 +: IDXW]] <= pend_reg.addr[31 -: TAGW];
            end
        end
    end
    // control sequencer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= L1CC_IDLE;
            pend_reg <= '0;
            wbAddr_reg <= '0;
            wbIdx_reg <= '0;
            wbInv_reg <= 1'b0;
            scan_reg <= '0;
            wbKeep_reg <= 1'b0;
            busCycle <= '0;
            coreAck <= 1'b0;
            purgeBusy <= 1'b0;
        end else begin
            coreAck <= 1'b0;
            case (state_reg)
                L1CC_IDLE: begin
                    busCycle <= '0;
                    if (inqGo && qDMod) begin
                        // dirty inquire hit: burst writeback first
                        wbAddr_reg <= inquireAddrBits;
                        wbIdx_reg <= qIdx;
                        wbInv_reg <= killLine;
                        busCycle <= '{1'b1, 1'b1, 1'b1, {inquireAddrBits, 5'h00},
                            6'(`L1CC_LINE_BYTES)};
                        state_reg <= L1CC_WBACK;
                    end else if (inqGo) begin
                        state_reg <= L1CC_IDLE; // core waits behind inquire
                    end else if (purgeReq) begin
                        wbKeep_reg <= purgeKeep;
                        scan_reg <= '0;
                        purgeBusy <= 1'b1;
                        state_reg <= purgeKeep ? L1CC_PWB : L1CC_PURGE;
                    end else if (coreReq.valid) begin
                        pend_reg <= coreReq;
                        if (xDMod) begin
                            // instr miss hit dirty data: writeback, then fill
                            wbAddr_reg <= coreReq.addr[31:5];
                            wbIdx_reg <= rIdx;
                            wbInv_reg <= 1'b1;
                            busCycle <= '{1'b1, 1'b1, 1'b1, {coreReq.addr[31:5], 5'h00},
                                6'(`L1CC_LINE_BYTES)};
                            state_reg <= L1CC_WBACK;
                        end else if (coreReq.isWrite && (!rDHit || rWThru)) begin
                            // writethrough or miss write: single cycle
                            busCycle <= '{1'b1, 1'b1, 1'b0, coreReq.addr, reqBytes};
                            state_reg <= L1CC_WRITE;
                        end else if (coreReq.isWrite || rHit) begin
                            coreAck <= 1'b1;
                            pend_reg <= '0; // nothing left pending after a hit
                        end else begin
                            // read miss: 32-byte burst line fill
                            busCycle <= '{1'b1, 1'b0, 1'b1, {coreReq.addr[31:5], 5'h00},
                                6'(`L1CC_LINE_BYTES)};
                            state_reg <= L1CC_FILL;
                        end
                    end
                end
                L1CC_WBACK: begin
                    if (busDone) begin
                        // writeback done: resume any pending fill
                        busCycle <= '0;
                        if (pend_reg.valid && pend_reg.isInstr) begin
                            busCycle <= '{1'b1, 1'b0, 1'b1, {pend_reg.addr[31:5], 5'h00},
                                6'(`L1CC_LINE_BYTES)};
                            state_reg <= L1CC_FILL;
                        end else begin
                            state_reg <= L1CC_IDLE;
                        end
                    end
                end
                L1CC_FILL, L1CC_WRITE: begin
                    if (busDone) begin
                        busCycle <= '0;
                        coreAck <= 1'b1;
                        pend_reg <= '0;
                        state_reg <= L1CC_IDLE;
                    end
                end
                L1CC_PWB: begin
                    // walk sets, writing back dirty lines
                    if (scan_reg == (IDXW+1)'(SETS)) begin
                        state_reg <= L1CC_PURGE;
                    end else if (sDirty && !busCycle.valid) begin
                        busCycle <= '{1'b1, 1'b1, 1'b1, {dTag_reg[sIdx], sIdx, 5'h00},
                            6'(`L1CC_LINE_BYTES)};
                    end else if (!sDirty || busDone) begin
                        busCycle <= '0;
                        scan_reg <= scan_reg + 1'b1;
                    end
                end
                L1CC_PURGE: begin
                    purgeBusy <= 1'b0;
                    busCycle <= '0;
                    state_reg <= L1CC_IDLE;
                end
                default: state_reg <= L1CC_IDLE;
            endcase
        end
    end
endmodule // l1cc_coherency

// ### testbench/l1cc_coherency_props.sv
// assertions on the coherency controller ports
`timescale 1ns/1ps
module l1cc_coherency_props
    import l1cc_pkg::*;
#(
    parameter int SETS = 8,
    parameter int IDXW = 3
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic addrBusFloatReq,
    input wire logic abortRetryReq,
    input wire logic busYieldReq,
    input wire logic extAddrStrobe,
    input wire logic killLine,
    input wire logic [31:5] inquireAddrBits,
    input wire logic cachePurge,
    input wire logic writebackPurgeOp,
    input wire logic discardPurgeOp,
    input wire l1cc_req_t coreReq,
    input wire logic busDone,
    input wire logic snoopMatch,
    input wire logic snoopDirtyMatch,
    input wire l1cc_bus_t busCycle,
    input wire logic coreAck,
    input wire logic purgeBusy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // some outside party owns the address bus
    wire busOwn = addrBusFloatReq | abortRetryReq | busYieldReq;
    property p_dirty; snoopDirtyMatch |-> snoopMatch; endproperty
    property p_cause; snoopMatch |-> $past(extAddrStrobe && busOwn); endproperty
    property p_wback; snoopDirtyMatch |-> busCycle.valid && busCycle.write && busCycle.burst;
    endproperty
    property p_burst;
        busCycle.valid && busCycle.burst |-> busCycle.bytes == 6'h20 && busCycle.addr[4:0] == 5'h00;
    endproperty
    property p_single;
        busCycle.valid && !busCycle.burst |-> busCycle.bytes inside {[6'h01:6'h08]};
    endproperty
    property p_hold; busCycle.valid && !busDone |=> $stable(busCycle); endproperty
    property p_ack; coreAck |=> !coreAck; endproperty
    property p_discard;
        $rose(purgeBusy) && $past(discardPurgeOp) && !$past(writebackPurgeOp) && !$past(cachePurge)
            |-> !busCycle.valid ##1 !busCycle.valid;
    endproperty
    property p_pend; $rose(purgeBusy) |-> ##[1:600] !purgeBusy; endproperty
    a_dirty: assert property (p_dirty) else $error("dirty match without match");
    a_cause: assert property (p_cause) else $error("match without owned strobe");
    a_wback: assert property (p_wback) else $error("dirty match without burst write");
    a_burst: assert property (p_burst) else $error("burst not one aligned line");
    a_single: assert property (p_single) else $error("single cycle size out of range");
    a_hold: assert property (p_hold) else $error("bus cycle changed before done");
    a_ack: assert property (p_ack) else $error("core ack longer than a cycle");
    a_discard: assert property (p_discard) else $error("discard purge used the bus");
    a_pend: assert property (p_pend) else $error("purge never ends");
    c_dirty: cover property (snoopDirtyMatch);
    c_purge: cover property (purgeBusy && busCycle.valid);
    c_single: cover property (busCycle.valid && !busCycle.burst);
endmodule // l1cc_coherency_props
bind l1cc_coherency l1cc_coherency_props #(.SETS(SETS), .IDXW(IDXW)) u_props (.clk(clk),
    .nrst(nrst), .addrBusFloatReq(addrBusFloatReq), .abortRetryReq(abortRetryReq),
    .busYieldReq(busYieldReq), .extAddrStrobe(extAddrStrobe), .killLine(killLine),
    .inquireAddrBits(inquireAddrBits), .cachePurge(cachePurge),
    .writebackPurgeOp(writebackPurgeOp), .discardPurgeOp(discardPurgeOp), .coreReq(coreReq),
    .busDone(busDone), .snoopMatch(snoopMatch), .snoopDirtyMatch(snoopDirtyMatch),
    .busCycle(busCycle), .coreAck(coreAck), .purgeBusy(purgeBusy));

// ### testbench/l1cc_mem_model.sv
// memory stand-in that finishes bus cycles
`timescale 1ns/1ps
module l1cc_mem_model
    import l1cc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic slow,
    input wire l1cc_bus_t busCycle,
    output logic busDone
);
    logic [3:0] waitCnt_reg; // wait states so far
    wire [3:0] lat = slow ? 4'h6 : 4'h0; // prompt or slow answer
    // one done pulse per cycle, after the wait states
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            waitCnt_reg <= 4'h0;
            busDone <= 1'b0;
        end else if (busDone || !busCycle.valid) begin
            waitCnt_reg <= 4'h0;
            busDone <= 1'b0;
        end else if (waitCnt_reg == lat) begin
            busDone <= 1'b1;
        end else begin
            waitCnt_reg <= waitCnt_reg + 4'h1;
        end
    end
endmodule // l1cc_mem_model

// ### testbench/tb_top.sv
// self-checking bench for the coherency controller
`timescale 1ns/1ps
module tb_top;
    import l1cc_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic busOwn = 1'b0, strobe = 1'b0, kill = 1'b0, slow = 1'b0;
    logic purge = 1'b0, wbPurge = 1'b0, discard = 1'b0;
    logic abortReq = 1'b0, yieldReq = 1'b0;
    logic [31:5] inqAddr = 27'h0;
    l1cc_req_t req = '0;
    l1cc_bus_t busCycle;
    logic busDone, match, dirty, ack, busy;
    l1cc_bus_t busLog[$]; // finished bus cycles
    int nErrors = 0;
    int checksDone = 0;
    always #5 clk = ~clk;
    l1cc_coherency DUT (.clk(clk), .nrst(nrst), .addrBusFloatReq(busOwn),
        .abortRetryReq(abortReq), .busYieldReq(yieldReq), .extAddrStrobe(strobe),
        .killLine(kill), .inquireAddrBits(inqAddr),
        .cachePurge(purge), .writebackPurgeOp(wbPurge), .discardPurgeOp(discard),
        .coreReq(req), .busDone(busDone), .snoopMatch(match), .snoopDirtyMatch(dirty),
        .busCycle(busCycle), .coreAck(ack), .purgeBusy(busy));
    l1cc_mem_model MEM (.clk(clk), .nrst(nrst), .slow(slow), .busCycle(busCycle),
        .busDone(busDone));
    // log each bus cycle as memory finishes it
    always @(posedge clk) if (busDone === 1'b1) busLog.push_back(busCycle);
    task automatic step(); @(posedge clk); #1; endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic finishTest();
        $display("errors %0d checks %0d", nErrors, checksDone);
        if (nErrors == 0 && checksDone > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic waitIdle();
        int n = 0;
        while ((busCycle.valid !== 1'b0 || busy !== 1'b0) && n < 400) begin
            step();
            n++;
        end
        if (n == 400) begin nErrors++; finishTest(); end
        else step();
    endtask
    task automatic core(logic i, logic w, logic [31:0] a);
        int n = 0;
        busLog.delete();
        req = '{1'b1, i, w, a, 4'h4};
        do begin step(); n++; end while (ack !== 1'b1 && n < 400);
        req.valid = 1'b0;
        if (n == 400) begin nErrors++; finishTest(); end
        else waitIdle();
    endtask
    task automatic inq(logic o, logic k, logic [31:0] a, logic m, logic d);
        busLog.delete();
        busOwn = o;
        step();
        strobe = 1'b1;
        kill = k;
        inqAddr = a[31:5];
        step();
        strobe = 1'b0;
        chk("snoop match", {31'h0, m}, {31'h0, match});
        chk("dirty match", {31'h0, d}, {31'h0, dirty});
        waitIdle();
        busOwn = 1'b0;
    endtask
    task automatic busAt(int i, logic w, logic b, logic [5:0] by, logic [31:0] a);
        chk("bus cycle", {24'h0, w, b, by},
            {24'h0, busLog[i].write, busLog[i].burst, busLog[i].bytes});
        chk("bus address", a, busLog[i].addr);
    endtask
    // fill, then a write hit on an exclusive line stays off the bus
    task automatic tFill();
        core(1'h0, 1'h0, 32'h0000_1040);
        busAt(0, 1'h0, 1'h1, 6'h20, 32'h0000_1040);
        core(1'h0, 1'h1, 32'h0000_1044);
        chk("bus count", 32'h0, busLog.size());
    endtask
    // inquiries on a dirty line, then kill and refused strobe
    task automatic tInq();
        inq(1'h1, 1'h0, 32'h0000_1040, 1'h1, 1'h1);
        chk("bus count", 32'h1, busLog.size());
        busAt(0, 1'h1, 1'h1, 6'h20, 32'h0000_1040);
        inq(1'h1, 1'h0, 32'h0000_1040, 1'h1, 1'h0);
        core(1'h0, 1'h1, 32'h0000_1048);
        busAt(0, 1'h1, 1'h0, 6'h04, 32'h0000_1048);
        inq(1'h0, 1'h0, 32'h0000_1040, 1'h0, 1'h0);
        inq(1'h1, 1'h1, 32'h0000_1040, 1'h1, 1'h0);
        inq(1'h1, 1'h0, 32'h0000_1040, 1'h0, 1'h0);
        // killed dirty line: written back first, then gone
        core(1'h0, 1'h0, 32'h0000_1040);
        core(1'h0, 1'h1, 32'h0000_1040);
        inq(1'h1, 1'h1, 32'h0000_1040, 1'h1, 1'h1);
        chk("bus count", 32'h1, busLog.size());
        busAt(0, 1'h1, 1'h1, 6'h20, 32'h0000_1040);
        inq(1'h1, 1'h0, 32'h0000_1040, 1'h0, 1'h0);
    endtask
    // instruction miss on a dirty data line, slow memory
    task automatic tSnoop();
        core(1'h0, 1'h0, 32'h0000_2060);
        core(1'h0, 1'h1, 32'h0000_2060);
        slow = 1'b1;
        core(1'h1, 1'h0, 32'h0000_2060);
        chk("bus count", 32'h2, busLog.size());
        busAt(0, 1'h1, 1'h1, 6'h20, 32'h0000_2060);
        busAt(1, 1'h0, 1'h1, 6'h20, 32'h0000_2060);
        inq(1'h1, 1'h0, 32'h0000_2060, 1'h1, 1'h0);
    endtask
    // data miss drops the instruction line, clean data line snooped away
    task automatic tCross();
        core(1'h0, 1'h0, 32'h0000_2060);
        chk("bus count", 32'h1, busLog.size());
        core(1'h1, 1'h0, 32'h0000_2060);
        chk("bus count", 32'h1, busLog.size());
        busAt(0, 1'h0, 1'h1, 6'h20, 32'h0000_2060);
        core(1'h1, 1'h0, 32'h0000_2060);
        chk("bus count", 32'h0, busLog.size());
        abortReq = 1'b1;
        inq(1'h0, 1'h0, 32'h0000_2060, 1'h1, 1'h0);
        abortReq = 1'b0;
        yieldReq = 1'b1;
        inq(1'h0, 1'h0, 32'h0000_2060, 1'h1, 1'h0);
        yieldReq = 1'b0;
    endtask
    // each purge kind on a dirty line
    task automatic tPurge();
        for (int k = 0; k < 3; k++) begin
            core(1'h1, 1'h0, 32'h0000_2060);
            core(1'h0, 1'h0, 32'h0000_3080);
            core(1'h0, 1'h1, 32'h0000_3080);
            busLog.delete();
            purge = (k == 0);
            wbPurge = (k == 1);
            discard = (k == 2);
            step();
            purge = 1'b0;
            wbPurge = 1'b0;
            discard = 1'b0;
            waitIdle();
            chk("purge writebacks", (k == 2) ? 32'h0 : 32'h1, busLog.size());
            if (k != 2) busAt(0, 1'h1, 1'h1, 6'h20, 32'h0000_3080);
            inq(1'h1, 1'h0, 32'h0000_3080, 1'h0, 1'h0);
            inq(1'h1, 1'h0, 32'h0000_2060, 1'h0, 1'h0);
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 nrst = 1'b1;
        step();
        tFill();
        tInq();
        tSnoop();
        tCross();
        tPurge();
        finishTest();
    end
endmodule // tb_top
